// [src/dcache_consts.vh]
// constants for the two-way write-through data cache
// assumes 32-bit byte addresses and 16-byte lines
`ifndef DCACHE_CONSTS_VH
`define DCACHE_CONSTS_VH

// address split: byte in word, word in line, set, tag
`define DC_BYTE_LSB   0
`define DC_WORD_LSB   2
`define DC_WORD_W     2
`define DC_SET_LSB    4
`define DC_SET_W      6
`define DC_TAG_LSB    10
`define DC_TAG_W      22

// access sizes on req_size_i
`define DC_SIZE_BYTE  2'h0
`define DC_SIZE_HALF  2'h1
`define DC_SIZE_WORD  2'h2

// test access selects
`define DC_TST_DATA   1'b0
`define DC_TST_TAG    1'b1

// bit of a tag readback that holds the valid flag
`define DC_TST_VALID_BIT 31

// reset value and last refill beat
`define DC_WB_CNT_RST 2'h0
`define DC_BEATS_LAST 2'h3

`endif

// [src/dcache.v]
// two-way set-associative write-through data cache, 2 Kbytes
// assumes one core clock; memory side is same-clock logic that may be
// paced at half rate, selected by the half_rate_i pin
`timescale 1ns/100ps
`default_nettype none
`include "dcache_consts.vh"

module dcache #(
    parameter WAYS  = 2,
    parameter SETS  = 64,
    parameter WORDS = 4
) (
    input  wire        clock_i,
    input  wire        rstn_i,
    input  wire        half_rate_i,
    input  wire        req_valid_i,
    input  wire        req_write_i,
    input  wire [1:0]  req_size_i,
    input  wire [31:0] req_addr_i,
    input  wire [31:0] req_wdata_i,
    output reg         stall_o,
    output reg         rdata_valid_o,
    output reg  [31:0] rdata_o,
    input  wire        tst_en_i,
    input  wire        tst_write_i,
    input  wire        tst_sel_i,
    input  wire        tst_way_i,
    input  wire [5:0]  tst_set_i,
    input  wire [1:0]  tst_word_i,
    input  wire [31:0] tst_wdata_i,
    output reg  [31:0] tst_rdata_o,
    output reg         mem_req_o,
    output reg         mem_write_o,
    output reg         mem_burst_o,
    output reg  [31:0] mem_addr_o,
    output reg  [31:0] mem_wdata_o,
    output reg  [3:0]  mem_be_o,
    input  wire        mem_ack_i,
    input  wire [31:0] mem_rdata_i
);
    localparam M_IDLE  = 2'h0;
    localparam M_WRITE = 2'h1;
    localparam M_FILL  = 2'h2;
    localparam LINES   = WAYS * SETS;

    // arrays: 2 ways x 64 sets x 4 words of 32 bits
    reg [31:0]                data_mem [0:LINES*WORDS-1];
    reg [`DC_TAG_W-1:0]       tag_mem  [0:LINES-1];
    reg [LINES-1:0]           valid_r;
    reg [SETS-1:0]            lru_r;
    reg                       half_meta_r;
    reg                       half_r;
    reg                       phase_r;
    reg [31:0]                wb_addr_r [0:1];
    reg [31:0]                wb_data_r [0:1];
    reg [3:0]                 wb_be_r   [0:1];
    reg                       wb_head_r;
    reg                       wb_tail_r;
    reg [1:0]                 wb_cnt_r;
    reg [1:0]                 mstate_r;
    reg                       fill_pend_r;
    reg [31:0]                fill_addr_r;
    reg [1:0]                 fill_size_r;
    reg                       fill_way_r;
    reg [1:0]                 fill_cnt_r;
    reg [1:0]                 fill_beats_r;

    wire [`DC_TAG_W-1:0] req_tag = req_addr_i[`DC_TAG_LSB +: `DC_TAG_W];
    wire [`DC_SET_W-1:0] req_set = req_addr_i[`DC_SET_LSB +: `DC_SET_W];
    wire [1:0]           req_wrd = req_addr_i[`DC_WORD_LSB +: `DC_WORD_W];
    wire [6:0] line0 = {1'b0, req_set};
    wire [6:0] line1 = {1'b1, req_set};
    wire hit0 = valid_r[line0] && (tag_mem[line0] == req_tag);
    wire hit1 = valid_r[line1] && (tag_mem[line1] == req_tag);
    wire hit  = hit0 | hit1;
    wire [31:0] hit_word = hit1 ? data_mem[{line1, req_wrd}]
                                : data_mem[{line0, req_wrd}];
    wire take     = req_valid_i & ~stall_o;
    wire take_ld  = take & ~req_write_i;
    wire take_st  = take & req_write_i;
    // at half rate the interface only moves on every other edge
    wire tick     = ~half_r | phase_r;
    wire mem_done = mem_req_o & mem_ack_i & tick;
    wire wb_pop   = mem_done & (mstate_r == M_WRITE);
    wire fill_ack = mem_done & (mstate_r == M_FILL);
    wire fill_end = fill_ack & (fill_beats_r == `DC_BEATS_LAST);
    wire tst_go   = tst_en_i & ~req_valid_i & ~fill_pend_r;
    wire [6:0] tst_line = {tst_way_i, tst_set_i};
    wire [6:0] fill_line = {fill_way_r, fill_addr_r[`DC_SET_LSB +: `DC_SET_W]};
    // victim: an empty way first, else the one not used last
    wire victim = ~valid_r[line0] ? 1'b0 :
                  ~valid_r[line1] ? 1'b1 : ~lru_r[req_set];

    // byte lanes and replicated store data
    reg [3:0]  st_be;
    reg [31:0] st_data;
    always @* begin
        if (req_size_i == `DC_SIZE_BYTE) begin
            st_be   = 4'h1 << req_addr_i[1:0];
            st_data = {4{req_wdata_i[7:0]}};
        end else if (req_size_i == `DC_SIZE_HALF) begin
            st_be   = req_addr_i[1] ? 4'hc : 4'h3;
            st_data = {2{req_wdata_i[15:0]}};
        end else begin
            st_be   = 4'hf;
            st_data = req_wdata_i;
        end
    end

    // load alignment; result is zero-extended, sign is the core's job
    function [31:0] align;
        input [31:0] w;
        input [1:0]  a;
        input [1:0]  s;
        reg   [31:0] sh;
        begin
            sh = w >> {a, 3'h0};
            if (s == `DC_SIZE_BYTE)
                align = {24'h000000, sh[7:0]};
            else if (s == `DC_SIZE_HALF)
                align = {16'h0000, sh[15:0]};
            else
                align = sh;
        end
    endfunction

    reg [1:0] wb_cnt_nxt;
    always @* begin
        wb_cnt_nxt = wb_cnt_r + {1'b0, take_st} - {1'b0, wb_pop};
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            half_meta_r <= 1'b0;
            half_r      <= 1'b0;
            phase_r     <= 1'b0;
        end else begin
            half_meta_r <= half_rate_i;
            half_r      <= half_meta_r;
            phase_r     <= ~phase_r;
        end
    end

    // storage arrays; refill has priority, stores and test stalled by then
    integer i;
    always @(posedge clock_i) begin
        if (fill_ack) begin
            data_mem[{fill_line, fill_cnt_r}] <= mem_rdata_i;
        end else if (tst_go && tst_write_i) begin
            if (tst_sel_i == `DC_TST_DATA)
                data_mem[{tst_line, tst_word_i}] <= tst_wdata_i;
            else
                tag_mem[tst_line] <= tst_wdata_i[`DC_TAG_W-1:0];
        end else if (take_st && hit) begin
            // write-through also updates a hit line, only its lanes
            for (i = 0; i < 4; i = i + 1) begin
                if (st_be[i])
                    data_mem[{hit1 ? line1 : line0, req_wrd}][i*8 +: 8]
                        <= st_data[i*8 +: 8];
            end
        end
        if (take_ld && !hit)
            tag_mem[{victim, req_set}] <= req_tag;
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            valid_r       <= {LINES{1'b0}};
            lru_r         <= {SETS{1'b0}};
            wb_head_r     <= 1'b0;
            wb_tail_r     <= 1'b0;
            wb_cnt_r      <= `DC_WB_CNT_RST;
            mstate_r      <= M_IDLE;
            fill_pend_r   <= 1'b0;
            fill_addr_r   <= 32'h00000000;
            fill_size_r   <= 2'h0;
            fill_way_r    <= 1'b0;
            fill_cnt_r    <= 2'h0;
            fill_beats_r  <= 2'h0;
            stall_o       <= 1'b0;
            rdata_valid_o <= 1'b0;
            rdata_o       <= 32'h00000000;
            tst_rdata_o   <= 32'h00000000;
            mem_req_o     <= 1'b0;
            mem_write_o   <= 1'b0;
            mem_burst_o   <= 1'b0;
            mem_addr_o    <= 32'h00000000;
            mem_wdata_o   <= 32'h00000000;
            mem_be_o      <= 4'h0;
        end else begin
            rdata_valid_o <= 1'b0;
            // hit answers on the next edge, no extra wait
            if (take_ld && hit) begin
                rdata_valid_o  <= 1'b1;
                rdata_o        <= align(hit_word, req_addr_i[1:0],
                                        req_size_i);
                lru_r[req_set] <= hit1;
            end
            if (take_st && hit)
                lru_r[req_set] <= hit1;
            if (take_ld && !hit) begin
                fill_pend_r        <= 1'b1;
                fill_addr_r        <= req_addr_i;
                fill_size_r        <= req_size_i;
                fill_way_r         <= victim;
                fill_cnt_r         <= req_wrd;
                fill_beats_r       <= 2'h0;
                valid_r[{victim, req_set}] <= 1'b0;
            end
            // every store is queued for memory, hit or miss
            if (take_st) begin
                wb_addr_r[wb_tail_r] <= req_addr_i;
                wb_data_r[wb_tail_r] <= st_data;
                wb_be_r[wb_tail_r]   <= st_be;
                wb_tail_r            <= ~wb_tail_r;
            end
            if (wb_pop)
                wb_head_r <= ~wb_head_r;
            wb_cnt_r <= wb_cnt_nxt;
            // full buffer or pending refill holds the pipeline
            stall_o <= (wb_cnt_nxt == 2'h2) | (take_ld & ~hit) |
                       (fill_pend_r & ~fill_end);
            if (tst_go) begin
                if (tst_sel_i == `DC_TST_DATA)
                    tst_rdata_o <= data_mem[{tst_line, tst_word_i}];
                else begin
                    tst_rdata_o <= {{(32-`DC_TAG_W){1'b0}}, tag_mem[tst_line]};
                    tst_rdata_o[`DC_TST_VALID_BIT] <= valid_r[tst_line];
                end
                if (tst_write_i && tst_sel_i == `DC_TST_TAG)
                    valid_r[tst_line] <= tst_wdata_i[`DC_TST_VALID_BIT];
            end
            case (mstate_r)
                M_IDLE: begin
                    // loads wait for the buffer to empty so they never
                    // read memory older than a queued store
                    if (tick && fill_pend_r && wb_cnt_r == 2'h0) begin
                        mstate_r    <= M_FILL;
                        mem_req_o   <= 1'b1;
                        mem_write_o <= 1'b0;
                        mem_burst_o <= 1'b1;
                        mem_be_o    <= 4'hf;
                        mem_addr_o  <= {fill_addr_r[31:4], fill_cnt_r,
                                        2'h0};
                    end else if (tick && wb_cnt_r != 2'h0) begin
                        mstate_r    <= M_WRITE;
                        mem_req_o   <= 1'b1;
                        mem_write_o <= 1'b1;
                        mem_burst_o <= 1'b0;
                        mem_addr_o  <= wb_addr_r[wb_head_r];
                        mem_wdata_o <= wb_data_r[wb_head_r];
                        mem_be_o    <= wb_be_r[wb_head_r];
                    end
                end
                M_WRITE: begin
                    if (wb_pop) begin
                        mstate_r    <= M_IDLE;
                        mem_req_o   <= 1'b0;
                        mem_write_o <= 1'b0;
                    end
                end
                M_FILL: begin
                    if (fill_ack) begin
                        // requested word goes straight to the core
                        if (fill_beats_r == 2'h0) begin
                            rdata_valid_o <= 1'b1;
                            rdata_o <= align(mem_rdata_i,
                                             fill_addr_r[1:0], fill_size_r);
                        end
                        fill_cnt_r   <= fill_cnt_r + 2'h1; // wraps in line
                        fill_beats_r <= fill_beats_r + 2'h1;
                        if (fill_end) begin
                            mstate_r            <= M_IDLE;
                            mem_req_o           <= 1'b0;
                            mem_burst_o         <= 1'b0;
                            fill_pend_r         <= 1'b0;
                            valid_r[fill_line]  <= 1'b1;
                            lru_r[fill_addr_r[`DC_SET_LSB +: `DC_SET_W]]
                                <= fill_way_r;
                        end
                    end
                end
                default: mstate_r <= M_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// [bench/dcache_monitor.sv]
// assertions on the cache core and memory ports
// sees only dcache ports; bound to every dcache instance at the foot
`timescale 1ns/100ps
`default_nettype none
module dcache_monitor (
    input wire logic        clock_i,
    input wire logic        rstn_i,
    input wire logic        req_valid_i,
    input wire logic        req_write_i,
    input wire logic [31:0] req_addr_i,
    input wire logic        stall_o,
    input wire logic        rdata_valid_o,
    input wire logic        mem_req_o,
    input wire logic        mem_write_o,
    input wire logic        mem_burst_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [3:0]  mem_be_o,
    input wire logic        mem_ack_i
);
    logic [31:0] lat_r;
    wire         take = req_valid_i & ~stall_o;
    wire         ld = take & ~req_write_i;
    wire         wr = mem_req_o & mem_write_o;
    // last taken address: a miss stalls, so it is the missed word
    always @(posedge clock_i or negedge rstn_i)
        if (!rstn_i)
            lat_r <= 32'h0;
        else if (take)
            lat_r <= req_addr_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    AST_HIT_NEXT: assert property (ld |=> rdata_valid_o || stall_o)
        else $error("load neither answered nor stalled");
    AST_DATA_CAUSE: assert property (rdata_valid_o |->
        $past(ld) || $past(mem_ack_i && mem_burst_o))
        else $error("stray data");
    AST_CRIT_WORD: assert property ($rose(mem_req_o) && mem_burst_o
        |-> mem_addr_o[31:2] == lat_r[31:2]) else $error("refill start wrong");
    AST_LOAD_THRU: assert property ($rose(mem_req_o && mem_burst_o)
        |-> ##[1:40] rdata_valid_o && stall_o) else $error("no early forward");
    AST_WR_THRU: assert property (take && req_write_i |->
        ##[1:100] wr) else $error("store not written through");
    AST_WR_SINGLE: assert property (wr |-> !mem_burst_o)
        else $error("write sent as burst");
    AST_BE_LANES: assert property (wr |-> mem_be_o inside
        {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf}) else $error("bad lanes");
    AST_MEM_HOLD: assert property (mem_req_o && !mem_ack_i |=>
        mem_req_o && $stable(mem_addr_o)) else $error("request moved");
    AST_STALL_END: assert property ($rose(stall_o) |->
        ##[1:120] !stall_o) else $error("stall never ends");
    C_HIT: cover property (ld ##1 rdata_valid_o && !stall_o);
    C_FWD: cover property (rdata_valid_o && stall_o);
    C_FULL: cover property (req_valid_i && req_write_i && stall_o);
endmodule
bind dcache dcache_monitor u_dcache_monitor (.clock_i(clock_i),
    .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .stall_o(stall_o), .rdata_valid_o(rdata_valid_o),
    .mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
    .mem_burst_o(mem_burst_o), .mem_addr_o(mem_addr_o),
    .mem_be_o(mem_be_o), .mem_ack_i(mem_ack_i));
`default_nettype wire

// [bench/mem_model.sv]
// memory side model: single writes and wrap-around refill bursts
// assumes requests stand until acked; half rate acks span two edges
`timescale 1ns/100ps
`default_nettype none
module mem_model (
    input wire logic        clock_i,
    input wire logic        half_i,
    input wire logic        slow_i,
    input wire logic        req_i,
    input wire logic        write_i,
    input wire logic        burst_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0]  be_i,
    output logic            ack_o,
    output logic [31:0]     rdata_o
);
    logic [31:0] mem [int];
    initial ack_o = 1'b0;
    initial rdata_o = 32'h0;
    function automatic logic [31:0] rd(input logic [29:0] w);
        return mem.exists(w) ? mem[w] : {~w[15:0], w[15:0]};
    endfunction
    always begin : serve
        int n;
        logic [31:0] a;
        @(posedge clock_i);
        if (req_i === 1'b1) begin
            a = addr_i;
            n = burst_i ? 4 : 1;
            if (write_i) begin
                mem[a[31:2]] = rd(a[31:2]);
                for (int b = 0; b < 4; b++)
                    if (be_i[b])
                        mem[a[31:2]][8*b+:8] = wdata_i[8*b+:8];
            end
            for (int b = 0; b < n; b++) begin
                repeat (slow_i ? 6 : $urandom_range(0, 2)) @(posedge clock_i);
                #1 ack_o = 1'b1;
                rdata_o = rd({a[31:4], 2'(a[3:2] + b[1:0])});
                // two edges at half rate so exactly one is a tick
                repeat (half_i ? 2 : 1) @(posedge clock_i);
                #1 ack_o = 1'b0;
                rdata_o = ~rdata_o;
            end
            @(posedge clock_i);
        end
    end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the data cache with a memory model behind it
// assumes dcache, mem_model and the bound monitor are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clock_i = 0, rstn_i = 0, half_rate_i = 0, slow = 0;
    logic        req_valid_i = 0, req_write_i = 0, tst_en_i = 0;
    logic        tst_write_i = 0, tst_sel_i = 0, tst_way_i = 0, saw_stall;
    logic [1:0]  req_size_i = 0, tst_word_i = 0;
    logic [5:0]  tst_set_i = 0;
    logic [31:0] req_addr_i = 0, req_wdata_i = 0, tst_wdata_i = 0, lag;
    logic        stall_o, rdata_valid_o, mem_req_o, mem_write_o;
    logic        mem_burst_o, mem_ack_i;
    logic [31:0] rdata_o, tst_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic [3:0]  mem_be_o;
    logic [31:0] shm [int];
    int          num_errors = 0, n_compared = 0, cyc = 0;
    always #2.5 clock_i = ~clock_i;
    dcache u_dcache (.clock_i(clock_i), .rstn_i(rstn_i),
        .half_rate_i(half_rate_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_size_i(req_size_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .stall_o(stall_o),
        .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .tst_en_i(tst_en_i),
        .tst_write_i(tst_write_i), .tst_sel_i(tst_sel_i),
        .tst_way_i(tst_way_i), .tst_set_i(tst_set_i), .tst_word_i(tst_word_i),
        .tst_wdata_i(tst_wdata_i), .tst_rdata_o(tst_rdata_o),
        .mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
        .mem_burst_o(mem_burst_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_be_o(mem_be_o),
        .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
    mem_model u_mem_model (.clock_i(clock_i), .half_i(half_rate_i),
        .slow_i(slow), .req_i(mem_req_o), .write_i(mem_write_o),
        .burst_i(mem_burst_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
        .be_i(mem_be_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    function automatic logic [31:0] mrd(input logic [29:0] w);
        return shm.exists(w) ? shm[w] : {~w[15:0], w[15:0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // one core access; held while stalled, shadow memory gives the answer
    task automatic acc(input logic w, input logic [1:0] sz,
                       input logic [31:0] a, d);
        int t;
        logic [31:0] x;
        t = 0;
        @(posedge clock_i);
        #1 {req_valid_i, req_write_i, req_size_i} = {1'b1, w, sz};
        {req_addr_i, req_wdata_i} = {a, d};
        while (stall_o !== 1'b0 && t < 200) begin
            saw_stall = 1'b1;
            @(posedge clock_i);
            #1 t++;
        end
        @(posedge clock_i);
        #1 req_valid_i = 1'b0;
        x = mrd(a[31:2]);
        t = 0;
        if (w) begin
            for (int b = 0; b < 4; b++)
                if (sz == 2'h2 || (sz == 2'h1 && b[1] == a[1]) ||
                    b[1:0] == a[1:0])
                    x[8*b+:8] =
                        d[8*(sz == 2'h2 ? b : (sz == 2'h1 ? b % 2 : 0))+:8];
            shm[a[31:2]] = x;
        end else begin
            while (rdata_valid_o !== 1'b1 && t < 400) begin
                @(posedge clock_i);
                #1 t++;
            end
            lag = t;
            x = x >> (8 * (sz == 2'h2 ? 0 :
                           (sz == 2'h1 ? a[1] * 2 : a[1:0])));
            x = x & (sz == 2'h2 ? 32'hffffffff :
                     (sz == 2'h1 ? 32'h0000ffff : 32'h000000ff));
            chk("load data", x, rdata_o);
        end
    endtask
    task automatic tst(input logic wr, sel, input logic [1:0] wd,
                       input logic [31:0] d);
        @(posedge clock_i);
        #1 {tst_en_i, tst_write_i, tst_sel_i, tst_way_i} =
            {1'b1, wr, sel, 1'b1};
        {tst_set_i, tst_word_i, tst_wdata_i} = {6'h09, wd, d};
        @(posedge clock_i);
        #1 tst_en_i = 1'b0;
    endtask
    // three tags over four sets forces misses, evictions and hits
    task automatic rnd(input int n, input string name);
        logic [1:0] sz;
        for (int i = 0; i < n; i++) begin
            sz = 2'($urandom_range(0, 2));
            acc($urandom_range(0, 2) == 0, sz,
                {20'h0, 2'($urandom_range(0, 2)), 4'h0, 2'($urandom),
                 2'($urandom), 2'($urandom) & (sz == 2'h2 ? 2'h0 :
                 (sz == 2'h1 ? 2'h2 : 2'h3))}, $urandom);
        end
        $display("test %s done", name);
    endtask
    initial begin
        void'($urandom(69));
        repeat (12) @(posedge clock_i);
        #1 rstn_i = 1'b1;
        tst(1'b1, 1'b1, 2'h0, 32'h800002a5);
        tst(1'b1, 1'b0, 2'h2, 32'h1234abcd);
        tst(1'b0, 1'b1, 2'h0, 32'h0);
        chk("tag", 32'h800002a5, tst_rdata_o & 32'h803fffff);
        tst(1'b0, 1'b0, 2'h2, 32'h0);
        chk("data word", 32'h1234abcd, tst_rdata_o);
        // set 9, word 2 under the preloaded tag: hits only if preload took
        shm[30'h02a526] = 32'h1234abcd;
        acc(1'b0, 2'h2, 32'h000a9498, 32'h0);
        chk("preload hit lag", 32'h0, lag);
        $display("test preload done");
        rnd(300, "random full rate");
        acc(1'b0, 2'h1, 32'h00000042, 32'h0);
        acc(1'b0, 2'h1, 32'h00000042, 32'h0);
        chk("hit lag", 32'h0, lag);
        slow = 1'b1;
        repeat (60) @(posedge clock_i);
        saw_stall = 1'b0;
        for (int i = 0; i < 4; i++)
            acc(1'b1, 2'h2, 32'h00000100 + 4 * i, $urandom);
        chk("store stall", 32'h1, {31'h0, saw_stall});
        slow = 1'b0;
        for (int i = 0; i < 4; i++)
            acc(1'b0, 2'h2, 32'h00000100 + 4 * i, 32'h0);
        $display("test write buffer done");
        // let the last refill drain: a rate change mid-burst loses beats
        repeat (40) @(posedge clock_i);
        #1 half_rate_i = 1'b1;
        repeat (8) @(posedge clock_i);
        rnd(200, "random half rate");
        report_and_stop();
    end
endmodule
`default_nettype wire
